/* cmc_comparator_control.sv */
// Comparator control: enable register, pin mode steering, settle timing and result capture
//
// Notes on behaviour
// - Comparisons may run while the chip is in active mode or in subactive mode.
// - In any other operating mode the comparator is powered down and compares nothing.
// - Select 00 picks input 0, 01 picks input 1, and any select with the upper bit set is unused.
// - Writing the run bit at bit 3 as 1 turns both shared pins analog and starts work; 0 restores them.
// - While running, neither shared pin reads as a port input, even the unselected one.
// - The enable register returns to its initial value on chip reset and on entering stop mode.
// - The enable register holds three meaningful bits, is write-only, and bit 2 is unused.
// - While comparing, the result of the selected input lands in the result bit of that input.
// - The result bit of the unselected input is undetermined and must not be relied on.
// - The result register keeps nothing once the run bit is 0.
// - The result register is read-only with two result bits and its upper two bits unused.
`timescale 1ns/1ps
`include "cmc_regs.svh"

module cmc_comparator_control #(
	parameter int unsigned SETTLE_CYCLES = `CMC_SETTLE_CYC
) (
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	input  wire logic [`CMC_ADDR_W-1:0] reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire cmc_pkg::cmc_nibble_t   reg_wdata,
	output cmc_pkg::cmc_nibble_t        reg_rdata,
	input  wire logic                   active_mode,
	input  wire logic                   subactive_mode,
	input  wire logic                   stop_mode,
	input  wire logic                   cmp_above_raw,
	input  wire logic [1:0]             pin_level_raw,
	output logic      [1:0]             pin_analog_en,
	output logic                        analog_sel,
	output logic                        cmp_power,
	output logic      [1:0]             port_level
);
	import cmc_pkg::*;

	// ==========================================================
	// Parameter checks
	// ==========================================================
	generate
		// The settle checker below counts two quiet cycles, so one cycle is too short
		if (SETTLE_CYCLES < 2 || SETTLE_CYCLES > 65535) begin : g_chk
			$error("cmc_comparator_control: SETTLE_CYCLES out of range 2..65535");
		end
	endgenerate

	// ==========================================================
	// Enable register
	// ==========================================================
	logic comparator_run_bit;
	logic input_select_high;
	logic input_select_low;

	wire logic hit_enable;
	wire logic hit_result;
	wire logic wr_enable;
	wire logic mode_ok;
	wire logic sel_valid;
	wire logic compare_go;

	assign hit_enable = (reg_addr == `CMC_ENABLE_OFS);
	assign hit_result = (reg_addr == `CMC_RESULT_OFS);
	assign wr_enable  = reg_wr && hit_enable;
	assign mode_ok    = (active_mode || subactive_mode) && !stop_mode;
	assign sel_valid  = !input_select_high;
	assign compare_go = comparator_run_bit && mode_ok && sel_valid;

	// Stop mode wins over a write in the same cycle, so the register is clean on wake-up
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			comparator_run_bit <= `CMC_ENABLE_RST;
			input_select_high  <= `CMC_ENABLE_RST;
			input_select_low   <= `CMC_ENABLE_RST;
		end else if (stop_mode) begin
			comparator_run_bit <= `CMC_ENABLE_RST;
			input_select_high  <= `CMC_ENABLE_RST;
			input_select_low   <= `CMC_ENABLE_RST;
		end else if (wr_enable) begin
			// Bit 2 is dropped on purpose
			comparator_run_bit <= reg_wdata[`CMC_RUN_POS];
			input_select_high  <= reg_wdata[`CMC_SEL_HI_POS];
			input_select_low   <= reg_wdata[`CMC_SEL_LO_POS];
		end
	end

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [2:0] sync_bus;
	wire logic  cmp_above;
	wire logic [1:0] pin_level;

	cmc_sync #(
		.WIDTH(3)
	) u_sync (
		.core_clk(core_clk),
		.arst_n  (arst_n),
		.async_in({cmp_above_raw, pin_level_raw}),
		.sync_out(sync_bus)
	);

	assign cmp_above = sync_bus[2];
	assign pin_level = sync_bus[1:0];

	// ==========================================================
	// Pin steering
	// ==========================================================
	// Look-ahead values keep the pin outputs in step with the enable register
	logic next_run;
	logic next_sel_lo;
	wire logic [1:0] next_port_level;

	// Both pins leave digital use together, whatever the select says; the look-ahead
	// keeps the port view dark in the very cycle the pins turn analog
	assign next_port_level = next_run ? 2'h0 : pin_level;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_analog_en <= 2'h0;
			analog_sel    <= 1'b0;
			port_level    <= 2'h0;
		end else begin
			pin_analog_en <= {2{next_run}};
			analog_sel    <= next_sel_lo;
			port_level    <= next_port_level;
		end
	end

	always_comb begin
		next_run    = comparator_run_bit;
		next_sel_lo = input_select_low;
		if (stop_mode) begin
			next_run    = 1'b0;
			next_sel_lo = 1'b0;
		end else if (wr_enable) begin
			next_run    = reg_wdata[`CMC_RUN_POS];
			next_sel_lo = reg_wdata[`CMC_SEL_LO_POS];
		end
	end

	// ==========================================================
	// Settle timing
	// ==========================================================
	// The analog stage needs time after power-up or a select change before its
	// decision means anything; capture waits for that rather than show garbage.
	cmc_state_t state;
	cmc_state_t next_state;
	logic [15:0] settle_cnt;
	logic        sel_seen;

	wire logic sel_changed;
	wire logic settle_done;
	wire logic capture;

	assign sel_changed = (sel_seen != input_select_low);
	assign settle_done = (settle_cnt == 16'(SETTLE_CYCLES - 1));
	// Right after a select change the synced decision still belongs to the old input
	assign capture     = (state == CMC_TRACK) && compare_go && !sel_changed;

	always_comb begin
		case (state)
			CMC_IDLE:
				next_state = compare_go ? CMC_SETTLE : CMC_IDLE;
			CMC_SETTLE:
				if (!compare_go)
					next_state = CMC_IDLE;
				else if (sel_changed)
					next_state = CMC_SETTLE;
				else
					next_state = settle_done ? CMC_TRACK : CMC_SETTLE;
			CMC_TRACK:
				if (!compare_go)
					next_state = CMC_IDLE;
				else
					next_state = sel_changed ? CMC_SETTLE : CMC_TRACK;
			default:
				next_state = CMC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state      <= CMC_IDLE;
			settle_cnt <= 16'h0000;
			sel_seen   <= 1'b0;
		end else begin
			state      <= next_state;
			sel_seen   <= input_select_low;
			settle_cnt <= (next_state == CMC_SETTLE && state == CMC_SETTLE && !sel_changed)
				? settle_cnt + 16'h0001 : 16'h0000;
		end
	end

	assign cmp_power = compare_go;

	// ==========================================================
	// Result register and read port
	// ==========================================================
	logic [1:0] result;
	wire logic  result_clear;
	cmc_nibble_t next_rdata;

	assign result_clear = !comparator_run_bit;

	cmc_result #(
		.INPUTS(2)
	) u_result (
		.core_clk(core_clk),
		.arst_n  (arst_n),
		.capture (capture),
		.clear   (result_clear),
		.sel     (input_select_low),
		.sample  (cmp_above),
		.result  (result)
	);

	// The enable register is write-only and reads as zero
	assign next_rdata = (reg_rd && hit_result) ? {2'h0, result} : 4'h0;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 4'h0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	stop_clears_enable_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		stop_mode |=> !comparator_run_bit && !input_select_low && !input_select_high)
		else $error("enable register not cleared by stop mode");

	halted_mode_power_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!(active_mode || subactive_mode) |-> !cmp_power && !capture)
		else $error("comparator powered outside active or subactive");

	run_starts_work_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		comparator_run_bit && active_mode && !stop_mode && !input_select_high
		|-> cmp_power)
		else $error("comparator not powered while running in active mode");

	write_sets_pins_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		wr_enable && !stop_mode |=> pin_analog_en == {2{$past(reg_wdata[3])}})
		else $error("pin mode does not follow the written run bit");

	pins_blocked_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		pin_analog_en != 2'h0 |-> port_level == 2'h0)
		else $error("port input visible while comparing");

	select_drives_mux_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 analog_sel == input_select_low)
		else $error("analog select out of step with the select bit");

	settle_before_capture_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(state == CMC_SETTLE) |-> !capture [*2])
		else $error("result captured before the settle time");

	capture_selected_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		capture && comparator_run_bit |=> result[$past(input_select_low)] == $past(cmp_above))
		else $error("selected result bit did not take the comparator decision");

	result_dropped_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!comparator_run_bit |=> result == 2'h0)
		else $error("result kept after the run bit cleared");

	read_upper_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		reg_rd && hit_result |=> reg_rdata[3:2] == 2'h0 && reg_rdata[1:0] == $past(result))
		else $error("result read returned wrong data");

	enable_write_only_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		reg_rd && hit_enable |=> reg_rdata == 4'h0)
		else $error("enable register is readable");

	// A capture in the switching cycle would file the old input's decision under the new one
	no_switch_capture_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		sel_changed |-> !capture)
		else $error("capture taken in the cycle the select moved");

	unused_select_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		input_select_high |-> !cmp_power && !capture)
		else $error("comparator working on an unused select");

	settle_count_bound_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		state == CMC_SETTLE |-> settle_cnt < 16'(SETTLE_CYCLES))
		else $error("settle counter ran past its end");

	pins_agree_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		pin_analog_en[0] == pin_analog_en[1])
		else $error("shared pins not switched together");

	stop_pins_digital_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		stop_mode |=> pin_analog_en == 2'h0 && !cmp_power)
		else $error("pins still analog after stop mode");

	rdata_idle_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!reg_rd |=> reg_rdata == 4'h0)
		else $error("read data shown without a read");

	subactive_runs_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		comparator_run_bit && subactive_mode && !stop_mode && !input_select_high
		|-> cmp_power)
		else $error("comparator not powered while running in subactive mode");

endmodule // cmc_comparator_control

/* cmc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the comparator control
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

`define CMC_ADDR_W       10
`define CMC_RESULT_OFS   10'h017
`define CMC_ENABLE_OFS   10'h018
`define CMC_SEL_LO_POS   0
`define CMC_SEL_HI_POS   1
`define CMC_RUN_POS      3
`define CMC_ENABLE_RST   1'b0
`define CMC_RESULT_RST   2'h0
`define CMC_CLK_NS       10
`define CMC_SETTLE_NS    1000
`define CMC_SETTLE_CYC   ((`CMC_SETTLE_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)

`endif

/* cmc_pkg.sv */
// Types shared by the comparator control modules
package cmc_pkg;

	typedef enum logic [1:0] {
		CMC_IDLE,
		CMC_SETTLE,
		CMC_TRACK
	} cmc_state_t;

	typedef logic [3:0] cmc_nibble_t;

endpackage

/* cmc_sync.sv */
// Two-flop synchroniser for levels arriving from pins and the analog comparator
`timescale 1ns/1ps

module cmc_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("cmc_sync: WIDTH must be at least 1");
		end
	endgenerate

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule // cmc_sync

/* cmc_result.sv */
// Result capture store: one bit per analog input, written only for the selected input
`timescale 1ns/1ps
`include "cmc_regs.svh"

module cmc_result #(
	parameter int unsigned INPUTS = 2
) (
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic              capture,
	input  wire logic              clear,
	input  wire logic              sel,
	input  wire logic              sample,
	output logic      [INPUTS-1:0] result
);

	generate
		if (INPUTS != 2) begin : g_chk
			$error("cmc_result: the select decode serves exactly two inputs");
		end
		for (genvar i = 0; i < INPUTS; i++) begin : g_bit
			wire logic hit;
			logic      held;
			assign hit = capture && (sel == 1'(i));
			// The bit of the other input just holds; software must not trust it
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					held <= 1'b0;
				end else if (clear) begin
					held <= 1'b0;
				end else if (hit) begin
					held <= sample;
				end
			end
			assign result[i] = held;
		end
	endgenerate

endmodule // cmc_result

/* test_comparator_control.sv */
// Self-checking testbench for the comparator control block
`timescale 1ns/1ps
`include "cmc_regs.svh"

module test_comparator_control;
	import cmc_pkg::*;

	logic        core_clk;
	logic        arst_n;
	logic [9:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	cmc_nibble_t reg_wdata;
	cmc_nibble_t reg_rdata;
	logic        active_mode;
	logic        subactive_mode;
	logic        stop_mode;
	logic        cmp_above_raw;
	logic [1:0]  pin_level_raw;
	logic [1:0]  pin_analog_en;
	logic        analog_sel;
	logic        cmp_power;
	logic [1:0]  port_level;
	cmc_nibble_t d;
	int          num_errors;
	int          n_compared;

	// Short settle time keeps the run brief; waits below allow sync plus settle
	cmc_comparator_control #(.SETTLE_CYCLES(2)) uut (
		.core_clk      (core_clk),
		.arst_n        (arst_n),
		.reg_addr      (reg_addr),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_wdata     (reg_wdata),
		.reg_rdata     (reg_rdata),
		.active_mode   (active_mode),
		.subactive_mode(subactive_mode),
		.stop_mode     (stop_mode),
		.cmp_above_raw (cmp_above_raw),
		.pin_level_raw (pin_level_raw),
		.pin_analog_en (pin_analog_en),
		.analog_sel    (analog_sel),
		.cmp_power     (cmp_power),
		.port_level    (port_level)
	);

	// ==========================================================
	// Clock, reset and shared tasks
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input cmc_nibble_t v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask

	task automatic rd(input logic [9:0] a, output cmc_nibble_t v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wrap_up;
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		check({2'b00, pin_analog_en}, 4'h0, "pins after reset");
		rd(`CMC_RESULT_OFS, d);
		check(d, 4'h0, "result after reset");
	endtask

	task automatic t_run_both;
		cmp_above_raw <= 1'b1;
		pin_level_raw <= 2'b11;
		wr(`CMC_ENABLE_OFS, 4'h8);
		check({2'b00, pin_analog_en}, 4'h3, "pins analog");
		check({2'b00, port_level}, 4'h0, "port view while running");
		check({cmp_power, analog_sel}, 4'h2, "power and input 0");
		wait_cyc(10);
		rd(`CMC_RESULT_OFS, d);
		check(d & 4'hd, 4'h1, "input 0 above");
		cmp_above_raw <= 1'b0;
		wait_cyc(10);
		rd(`CMC_RESULT_OFS, d);
		check(d & 4'hd, 4'h0, "input 0 below");
		cmp_above_raw <= 1'b1;
		wr(`CMC_ENABLE_OFS, 4'h9);
		check({3'b000, analog_sel}, 4'h1, "input 1 selected");
		wait_cyc(10);
		rd(`CMC_RESULT_OFS, d);
		check(d & 4'he, 4'h2, "input 1 above");
	endtask

	task automatic t_bit2_and_wo;
		// Unused bit 2 must not disturb the select
		wr(`CMC_ENABLE_OFS, 4'hc);
		check({1'b0, pin_analog_en, analog_sel}, 4'h6, "bit 2 ignored");
		rd(`CMC_ENABLE_OFS, d);
		check(d, 4'h0, "enable register unreadable");
	endtask

	task automatic t_stop;
		@(posedge core_clk);
		stop_mode <= 1'b1;
		@(posedge core_clk);
		stop_mode <= 1'b0;
		wait_cyc(2);
		check({1'b0, pin_analog_en, cmp_power}, 4'h0, "stop clears");
		pin_level_raw <= 2'b10;
		wait_cyc(4);
		check({2'b00, port_level}, 4'h2, "port view restored");
		rd(`CMC_RESULT_OFS, d);
		check(d, 4'h0, "result dropped");
	endtask

	task automatic t_modes;
		active_mode    <= 1'b0;
		subactive_mode <= 1'b1;
		cmp_above_raw  <= 1'b1;
		wr(`CMC_ENABLE_OFS, 4'h8);
		check({3'b000, cmp_power}, 4'h1, "subactive runs");
		wait_cyc(10);
		rd(`CMC_RESULT_OFS, d);
		check(d & 4'h1, 4'h1, "subactive capture");
		subactive_mode <= 1'b0;
		cmp_above_raw  <= 1'b0;
		wait_cyc(10);
		check({3'b000, cmp_power}, 4'h0, "halted");
		rd(`CMC_RESULT_OFS, d);
		check(d & 4'h1, 4'h1, "no capture while halted");
		active_mode <= 1'b1;
		wr(`CMC_ENABLE_OFS, 4'h0);
	endtask

	task automatic t_high_sel;
		wr(`CMC_ENABLE_OFS, 4'ha);
		check({1'b0, pin_analog_en, cmp_power}, 4'h6, "unused select");
		wr(`CMC_ENABLE_OFS, 4'h0);
		check({2'b00, pin_analog_en}, 4'h0, "run cleared");
	endtask

	task automatic t_other_addr;
		wr(10'h019, 4'h8);
		wr(`CMC_RESULT_OFS, 4'hf);
		check({2'b00, pin_analog_en}, 4'h0, "stray write ignored");
		rd(`CMC_RESULT_OFS, d);
		check(d, 4'h0, "result not writable");
		rd(10'h3ff, d);
		check(d, 4'h0, "unmapped read");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		arst_n         = 1'b0;
		reg_addr       = 10'h000;
		reg_wr         = 1'b0;
		reg_rd         = 1'b0;
		reg_wdata      = 4'h0;
		active_mode    = 1'b1;
		subactive_mode = 1'b0;
		stop_mode      = 1'b0;
		cmp_above_raw  = 1'b0;
		pin_level_raw  = 2'b00;
		num_errors     = 0;
		n_compared     = 0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		#1;
		t_reset();
		t_run_both();
		t_bit2_and_wo();
		t_stop();
		t_modes();
		t_high_sel();
		t_other_addr();
		wrap_up();
	end

	// Tests need about 110 cycles; far longer means a hang
	initial begin
		#50000;
		num_errors++;
		wrap_up();
	end

endmodule // test_comparator_control
